//--- pkg/fmt_decode_pkg.sv
// Constants and types for the compact instruction format and target decoder.
// Contract
// - Three-way format code: 0 single, 1 double, 2 paired single, 3 reserved.
// - One-bit format field: 0 single, 1 double.
// - Single/word/long format code: 0 single, 1 word, 2 long, 3 reserved.
// - Double/word/long format code: 0 double, 1 word, 2 long, 3 reserved.
// - Reserved format codes raise a flag instead of a valid operation.
// - Branch targets may sit on any halfword boundary.
// - 32-bit branch offset keeps base width; counted in halfwords, range halves.
// - Absolute jumps stay inside the current 128 MB aligned region.
// - Register jumps take the whole target from a register.
// - Branch-likely encodings are not implemented and are refused.
// - All-zero word is the long no-op; halfword 0x0c00 the short no-op.
// - Compact mode uses the common mode switch and coexists with base encoding.
// - Mode changes on cross-mode jump-link or register jump by target bit zero.
// - Offsets are shifted left by one bit, not two; the cross-mode jump-link index is shifted left by two.
// - Instructions straddling line or page boundaries are decoded normally.
`default_nettype none
package fmt_decode_pkg;

  typedef enum logic [2:0] {
    FMT_GROUP_SD_PS,
    FMT_GROUP_SD_1BIT,
    FMT_GROUP_SWL,
    FMT_GROUP_DWL,
    FMT_GROUP_NONE
  } fmt_group_t;

  typedef enum logic [2:0] {
    FORMAT_SINGLE,
    FORMAT_DOUBLE,
    FORMAT_PAIRED,
    FORMAT_WORD,
    FORMAT_LONG,
    FORMAT_NONE
  } fmt_kind_t;

  typedef enum logic [2:0] {
    FLOW_NONE,
    FLOW_BRANCH,
    FLOW_ABS_JUMP,
    FLOW_ABS_JUMP_LINK,
    FLOW_CROSS_JUMP_LINK,
    FLOW_REG_JUMP,
    FLOW_BRANCH_LIKELY
  } flow_kind_t;

  localparam logic [1:0] FMT_CODE_0 = 2'h0;
  localparam logic [1:0] FMT_CODE_1 = 2'h1;
  localparam logic [1:0] FMT_CODE_2 = 2'h2;
  localparam logic [1:0] FMT_CODE_3 = 2'h3;

  localparam logic [6:0] WIDTH_32 = 7'h20;
  localparam logic [6:0] WIDTH_64 = 7'h40;

  localparam logic [31:0] LONG_NOP_WORD = 32'h0000_0000;
  localparam logic [15:0] SHORT_NOP_HALF = 16'h0c00;

  // Offset fields are in halfwords, so one shift bit; base encoding used two.
  localparam int OFFSET_SHIFT = 1;
  localparam int BRANCH_OFFSET_BITS = 16;
  // 128 MB region: the jump keeps pc[31:27] and fills 27 bits below it.
  localparam int JUMP_INDEX_BITS = 26;
  localparam int REGION_LOW_BITS = 27;

  localparam logic [31:0] RESET_PC = 32'h0000_0000;

endpackage : fmt_decode_pkg

`default_nettype wire

//--- core/fmt_target_decoder.sv
// Format decode, halfword target generation and mode tracking for compact code.
`timescale 1ns/1ps
`default_nettype none

module fmt_target_decoder
  import fmt_decode_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic IN_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic IS_SHORT,
  input wire logic [31:0] INSTR_PC,
  input wire logic [2:0] FMT_GROUP,
  input wire logic [1:0] FMT_CODE,
  input wire logic [2:0] FLOW_KIND,
  input wire logic [15:0] BRANCH_OFFSET,
  input wire logic [25:0] JUMP_INDEX,
  input wire logic [31:0] JUMP_REG_VALUE,
  output logic OUT_VALID,
  output logic [2:0] OPERAND_FORMAT,
  output logic [6:0] OPERAND_WIDTH,
  output logic OPERAND_IS_FLOAT,
  output logic RESERVED_FORMAT,
  output logic UNSUPPORTED_OP,
  output logic SHORT_NO_OPERATION,
  output logic LONG_NO_OPERATION,
  output logic TARGET_VALID,
  output logic [31:0] TARGET_ADDR,
  output logic INSTRUCTION_SET_SELECT_BIT
);

  ////////////////////////////////////////////////////////////////////////////
  // Format decode.

  fmt_kind_t kind_c;
  logic [6:0] width_c;
  logic float_c;
  logic reserved_c;

  always_comb begin
    kind_c = FORMAT_NONE;
    reserved_c = 1'b0;
    unique case (fmt_group_t'(FMT_GROUP))
      FMT_GROUP_SD_PS: begin
        unique case (FMT_CODE)
          FMT_CODE_0: kind_c = FORMAT_SINGLE;
          FMT_CODE_1: kind_c = FORMAT_DOUBLE;
          FMT_CODE_2: kind_c = FORMAT_PAIRED;
          FMT_CODE_3: reserved_c = 1'b1;
        endcase
      end
      FMT_GROUP_SD_1BIT: begin
        // Only the low bit is a format field here.
        kind_c = FMT_CODE[0] ? FORMAT_DOUBLE : FORMAT_SINGLE;
      end
      FMT_GROUP_SWL: begin
        unique case (FMT_CODE)
          FMT_CODE_0: kind_c = FORMAT_SINGLE;
          FMT_CODE_1: kind_c = FORMAT_WORD;
          FMT_CODE_2: kind_c = FORMAT_LONG;
          FMT_CODE_3: reserved_c = 1'b1;
        endcase
      end
      FMT_GROUP_DWL: begin
        unique case (FMT_CODE)
          FMT_CODE_0: kind_c = FORMAT_DOUBLE;
          FMT_CODE_1: kind_c = FORMAT_WORD;
          FMT_CODE_2: kind_c = FORMAT_LONG;
          FMT_CODE_3: reserved_c = 1'b1;
        endcase
      end
      default: begin
        kind_c = FORMAT_NONE;
      end
    endcase
  end

  // Paired single reports the width of one lane; the pipeline knows it is two.
  always_comb begin
    width_c = 7'h00;
    float_c = 1'b0;
    unique case (kind_c)
      FORMAT_SINGLE: begin
        width_c = WIDTH_32;
        float_c = 1'b1;
      end
      FORMAT_DOUBLE: begin
        width_c = WIDTH_64;
        float_c = 1'b1;
      end
      FORMAT_PAIRED: begin
        width_c = WIDTH_32;
        float_c = 1'b1;
      end
      FORMAT_WORD: width_c = WIDTH_32;
      FORMAT_LONG: width_c = WIDTH_64;
      default: width_c = 7'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target generation.

  logic [31:0] pc_next_seq;
  logic [31:0] branch_offset_ext;
  logic [31:0] branch_target;
  logic [31:0] jump_target;
  logic [31:0] target_c;
  logic target_valid_c;
  logic unsupported_c;
  logic mode_change_c;
  logic mode_value_c;
  flow_kind_t flow;

  assign flow = flow_kind_t'(FLOW_KIND);
  // Base for relative targets is the address after the instruction.
  assign pc_next_seq = INSTR_PC + (IS_SHORT ? 32'h0000_0002 : 32'h0000_0004);
  // Same 16-bit field as the word-aligned form; halfword units halve the reach.
  assign branch_offset_ext = {{15{BRANCH_OFFSET[15]}}, BRANCH_OFFSET, 1'b0};
  assign branch_target = pc_next_seq + branch_offset_ext;
  // Upper five pc bits keep the jump inside its 128 MB aligned region.
  assign jump_target = {pc_next_seq[31:27], JUMP_INDEX, 1'b0};

  always_comb begin
    target_c = 32'h0000_0000;
    target_valid_c = 1'b0;
    unsupported_c = 1'b0;
    mode_change_c = 1'b0;
    mode_value_c = 1'b1;
    unique case (flow)
      FLOW_BRANCH: begin
        target_c = branch_target;
        target_valid_c = 1'b1;
      end
      FLOW_ABS_JUMP, FLOW_ABS_JUMP_LINK: begin
        target_c = jump_target;
        target_valid_c = 1'b1;
      end
      FLOW_CROSS_JUMP_LINK: begin
        // The far side is the word-aligned encoding, so index is in words.
        target_c = {pc_next_seq[31:28], JUMP_INDEX, 2'b00};
        target_valid_c = 1'b1;
        mode_change_c = 1'b1;
        mode_value_c = ~INSTRUCTION_SET_SELECT_BIT;
      end
      FLOW_REG_JUMP: begin
        // Full register value reaches anywhere; bit zero selects the mode.
        target_c = {JUMP_REG_VALUE[31:1], 1'b0};
        target_valid_c = 1'b1;
        mode_change_c = 1'b1;
        mode_value_c = JUMP_REG_VALUE[0];
      end
      FLOW_BRANCH_LIKELY: unsupported_c = 1'b1;
      default: target_valid_c = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers and mode state.

  logic out_valid_reg;
  logic out_valid_next;
  logic [2:0] format_reg;
  logic [2:0] format_next;
  logic [6:0] width_reg;
  logic [6:0] width_next;
  logic float_reg;
  logic float_next;
  logic reserved_reg;
  logic reserved_next;
  logic unsupported_reg;
  logic unsupported_next;
  logic short_nop_reg;
  logic short_nop_next;
  logic long_nop_reg;
  logic long_nop_next;
  logic target_valid_reg;
  logic target_valid_next;
  logic [31:0] target_reg;
  logic [31:0] target_next;
  logic mode_reg;
  logic mode_next;

  // Fetch hands over whole assembled instructions, so line and page
  // straddling is invisible here and needs no special case.
  always_comb begin
    out_valid_next = IN_VALID;
    format_next = 3'(kind_c);
    width_next = width_c;
    float_next = float_c;
    reserved_next = IN_VALID & reserved_c;
    unsupported_next = IN_VALID & unsupported_c;
    short_nop_next = IN_VALID & IS_SHORT & (INSTR_WORD[15:0] == SHORT_NOP_HALF);
    long_nop_next = IN_VALID & ~IS_SHORT & (INSTR_WORD == LONG_NOP_WORD);
    // A reserved format must not steer control flow either.
    target_valid_next = IN_VALID & target_valid_c & ~reserved_c;
    target_next = target_c;
    mode_next = mode_reg;
    if (IN_VALID && mode_change_c && !reserved_c) begin
      mode_next = mode_value_c;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      out_valid_reg <= 1'b0;
      format_reg <= 3'(FORMAT_NONE);
      width_reg <= 7'h00;
      float_reg <= 1'b0;
      reserved_reg <= 1'b0;
      unsupported_reg <= 1'b0;
      short_nop_reg <= 1'b0;
      long_nop_reg <= 1'b0;
      target_valid_reg <= 1'b0;
      target_reg <= RESET_PC;
      mode_reg <= 1'b1;
    end else begin
      out_valid_reg <= out_valid_next;
      format_reg <= format_next;
      width_reg <= width_next;
      float_reg <= float_next;
      reserved_reg <= reserved_next;
      unsupported_reg <= unsupported_next;
      short_nop_reg <= short_nop_next;
      long_nop_reg <= long_nop_next;
      target_valid_reg <= target_valid_next;
      target_reg <= target_next;
      mode_reg <= mode_next;
    end
  end

  assign OUT_VALID = out_valid_reg;
  assign OPERAND_FORMAT = format_reg;
  assign OPERAND_WIDTH = width_reg;
  assign OPERAND_IS_FLOAT = float_reg;
  assign RESERVED_FORMAT = reserved_reg;
  assign UNSUPPORTED_OP = unsupported_reg;
  assign SHORT_NO_OPERATION = short_nop_reg;
  assign LONG_NO_OPERATION = long_nop_reg;
  assign TARGET_VALID = target_valid_reg;
  assign TARGET_ADDR = target_reg;
  assign INSTRUCTION_SET_SELECT_BIT = mode_reg;

endmodule : fmt_target_decoder

`default_nettype wire

//--- verif/exec_sink.sv
// Pipeline-side stand-in that takes each decoded result and counts redirects.
`timescale 1ns/1ps
`default_nettype none
module exec_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic valid,
  input wire logic redirect,
  output logic [15:0] redirects
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      redirects <= 16'h0;
    end else if (valid && redirect) begin
      redirects <= redirects + 16'h1;
    end
  end
endmodule : exec_sink
`default_nettype wire

//--- verif/fmt_decoder_properties.sv
// Port-level assertions for the format and target decoder.
`timescale 1ns/1ps
`default_nettype none
module fmt_decoder_props
  import fmt_decode_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic IN_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic IS_SHORT,
  input wire logic [2:0] FMT_GROUP,
  input wire logic [1:0] FMT_CODE,
  input wire logic [2:0] FLOW_KIND,
  input wire logic [25:0] JUMP_INDEX,
  input wire logic [31:0] JUMP_REG_VALUE,
  input wire logic OUT_VALID,
  input wire logic [2:0] OPERAND_FORMAT,
  input wire logic RESERVED_FORMAT,
  input wire logic UNSUPPORTED_OP,
  input wire logic SHORT_NO_OPERATION,
  input wire logic LONG_NO_OPERATION,
  input wire logic TARGET_VALID,
  input wire logic [31:0] TARGET_ADDR,
  input wire logic INSTRUCTION_SET_SELECT_BIT
);
  // The one-bit group has no spare code, so it never counts as reserved.
  wire logic rsv = FMT_CODE == FMT_CODE_3 && FMT_GROUP inside {3'h0, 3'h2, 3'h3};
  wire logic go = IN_VALID && !rsv;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  valid_echo_a: assert property (IN_VALID |=> OUT_VALID)
    else $error("result valid missing");
  reserved_flag_a: assert property (
    IN_VALID && rsv |=> RESERVED_FORMAT && !TARGET_VALID && OPERAND_FORMAT == FORMAT_NONE)
    else $error("reserved code not flagged");
  likely_refused_a: assert property (
    IN_VALID && FLOW_KIND == 3'h6 |=> UNSUPPORTED_OP && !TARGET_VALID)
    else $error("branch-likely accepted");
  short_nop_a: assert property (
    IN_VALID && IS_SHORT && INSTR_WORD[15:0] == SHORT_NOP_HALF |=> SHORT_NO_OPERATION)
    else $error("short no-op missed");
  long_nop_a: assert property (
    IN_VALID && !IS_SHORT && INSTR_WORD == LONG_NOP_WORD |=> LONG_NO_OPERATION)
    else $error("long no-op missed");
  jump_index_a: assert property (
    go && FLOW_KIND inside {3'h2, 3'h3} |=> TARGET_VALID
    && TARGET_ADDR[26:0] == {$past(JUMP_INDEX), 1'b0}) else $error("jump target bad");
  reg_jump_a: assert property (
    go && FLOW_KIND == 3'h5 |=> {TARGET_ADDR[31:1], INSTRUCTION_SET_SELECT_BIT}
    == $past(JUMP_REG_VALUE)) else $error("reg jump bad");
  cross_toggle_a: assert property (
    go && FLOW_KIND == 3'h4 |=> INSTRUCTION_SET_SELECT_BIT
    != $past(INSTRUCTION_SET_SELECT_BIT)) else $error("mode did not switch");
endmodule : fmt_decoder_props
////////////////////////////////////////////////////////////////////////
bind fmt_target_decoder fmt_decoder_props props (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .IN_VALID(IN_VALID), .INSTR_WORD(INSTR_WORD), .IS_SHORT(IS_SHORT), .FMT_GROUP(FMT_GROUP),
  .FMT_CODE(FMT_CODE), .FLOW_KIND(FLOW_KIND), .JUMP_INDEX(JUMP_INDEX),
  .JUMP_REG_VALUE(JUMP_REG_VALUE), .OUT_VALID(OUT_VALID), .OPERAND_FORMAT(OPERAND_FORMAT),
  .RESERVED_FORMAT(RESERVED_FORMAT), .UNSUPPORTED_OP(UNSUPPORTED_OP),
  .SHORT_NO_OPERATION(SHORT_NO_OPERATION), .LONG_NO_OPERATION(LONG_NO_OPERATION),
  .TARGET_VALID(TARGET_VALID), .TARGET_ADDR(TARGET_ADDR),
  .INSTRUCTION_SET_SELECT_BIT(INSTRUCTION_SET_SELECT_BIT));
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the format and target decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import fmt_decode_pkg::*;
;
  logic clk = 0, rst = 1, iv = 0, sh = 0, me = 1;
  logic [31:0] wd = 0, pc = 0, jr = 0, ta;
  logic [2:0] grp = 0, flw = 0, fo;
  logic [1:0] cd = 0;
  logic [15:0] off = 0;
  logic [25:0] ji = 0;
  logic [6:0] wo;
  logic ov, fl, rf, un, sn, ln, tv, md;
  logic [48:0] q[$];
  int mismatches = 0, num_checks = 0;
  int redir_exp = 0;
  logic [15:0] redir;
  logic [48:0] got, want;
  initial forever #5 clk = !clk;
  fmt_target_decoder dut (.SYS_CLK(clk), .RESET(rst), .IN_VALID(iv), .INSTR_WORD(wd),
    .IS_SHORT(sh), .INSTR_PC(pc), .FMT_GROUP(grp), .FMT_CODE(cd), .FLOW_KIND(flw),
    .BRANCH_OFFSET(off), .JUMP_INDEX(ji), .JUMP_REG_VALUE(jr), .OUT_VALID(ov),
    .OPERAND_FORMAT(fo), .OPERAND_WIDTH(wo), .OPERAND_IS_FLOAT(fl), .RESERVED_FORMAT(rf),
    .UNSUPPORTED_OP(un), .SHORT_NO_OPERATION(sn), .LONG_NO_OPERATION(ln),
    .TARGET_VALID(tv), .TARGET_ADDR(ta), .INSTRUCTION_SET_SELECT_BIT(md));
  exec_sink sink (.clk(clk), .rst(rst), .valid(ov), .redirect(tv), .redirects(redir));
////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [48:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // Drives one instruction and notes the expected decode; mode is tracked here too.
  task automatic issue(input logic [2:0] g, input logic [1:0] c, input logic [2:0] f,
      input logic s, input logic [31:0] w, p, r, input logic [15:0] o, input logic [25:0] j);
    logic [2:0] k;
    logic rs, t;
    logic [31:0] n, a;
    @(negedge clk);
    {iv, grp, cd, flw, sh, wd, pc, jr, off, ji} = {1'b1, g, c, f, s, w, p, r, o, j};
    rs = c == 2'h3 && g inside {3'h0, 3'h2, 3'h3};
    case (g)
      3'h0: k = rs ? FORMAT_NONE : {1'b0, c};
      3'h1: k = c[0] ? FORMAT_DOUBLE : FORMAT_SINGLE;
      3'h2, 3'h3: k = rs ? FORMAT_NONE : c == 2'h1 ? FORMAT_WORD : c == 2'h2 ? FORMAT_LONG
        : g[0] ? FORMAT_DOUBLE : FORMAT_SINGLE;
      default: k = FORMAT_NONE;
    endcase
    n = p + (s ? 32'h2 : 32'h4);
    t = f inside {[3'h1:3'h5]} && !rs;
    case (f)
      3'h1: a = n + {{15{o[15]}}, o, 1'b0};
      3'h2, 3'h3: a = {n[31:27], j, 1'b0};
      3'h4: a = {n[31:28], j, 2'h0};
      default: a = {r[31:1], 1'b0};
    endcase
    if (t && f == 3'h4) me = !me;
    if (t && f == 3'h5) me = r[0];
    if (t) redir_exp++;
    q.push_back({k, k == FORMAT_NONE ? 7'h0 : k inside {FORMAT_DOUBLE, FORMAT_LONG} ?
      WIDTH_64 : WIDTH_32, k <= FORMAT_PAIRED, rs, f == 3'h6, s && w[15:0] == SHORT_NOP_HALF,
      !s && w == LONG_NOP_WORD, t, t ? a : 32'h0, me});
  endtask : issue
  always @(posedge clk) begin
    #1;
    if (ov === 1'b1) begin
      got = {fo, wo, fl, rf, un, sn, ln, tv, tv ? ta : 32'h0, md};
      // A result with no note behind it must count as a mismatch.
      want = q.size() > 0 ? q.pop_front() : ~got;
      check("format", 49'(got[48:37]), 49'(want[48:37]));
      check("flow", 49'(got[36:0]), 49'(want[36:0]));
    end
  end
  initial begin
    void'($urandom(32'h997e));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 0;
    check("reset state", 49'({fo, md}), 49'({FORMAT_NONE, 1'b1}));
    issue(3'h4, 2'h0, 3'h1, 1'b1, 32'h0, 32'h100, 32'h0, 16'h3, 26'h0);
    issue(3'h4, 2'h0, 3'h1, 1'b0, 32'h0, 32'h1000, 32'h0, 16'hfffe, 26'h0);
    issue(3'h4, 2'h0, 3'h0, 1'b1, 32'h0c00, 32'h0, 32'h0, 16'h0, 26'h0);
    issue(3'h4, 2'h0, 3'h2, 1'b1, 32'h1, 32'h07ff_fffe, 32'h0, 16'h0, 26'h3ff_ffff);
    issue(3'h4, 2'h0, 3'h4, 1'b0, 32'h1, 32'h2000, 32'h0, 16'h0, 26'h155_5555);
    issue(3'h0, 2'h3, 3'h4, 1'b0, 32'h1, 32'h0, 32'h0, 16'h0, 26'h0);
    issue(3'h4, 2'h0, 3'h5, 1'b0, 32'h1, 32'h0, 32'h8765_4321, 16'h0, 26'h0);
    issue(3'h4, 2'h0, 3'h6, 1'b0, 32'h1, 32'h0, 32'h0, 16'h0, 26'h0);
    $display("test directed done");
    for (int g = 0; g < 5; g++) begin
      for (int c = 0; c < 4; c++) begin
        issue(3'(g), 2'(c), 3'h2, 1'b0, 32'h1, 32'h4000_0000, 32'h0, 16'h0, 26'h2aa_aaaa);
      end
    end
    $display("test format table done");
    repeat (300) begin
      issue(3'($urandom), 2'($urandom), 3'($urandom), 1'($urandom),
        $urandom_range(1) ? 32'h0 : $urandom, $urandom, $urandom, 16'($urandom), 26'($urandom));
    end
    $display("test random done");
    @(negedge clk);
    iv = 0;
    repeat (3) @(posedge clk);
    check("pending notes", 49'(q.size()), 49'h0);
    check("redirects", 49'(redir), 49'(redir_exp));
    wrap_up();
  end
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
